// >>> rtl/dual_level_irq_ctrl.v
// Dual-level interrupt controller with APB registers and optional vectored nesting
// How it works
// - In plain mode normal request is OR of all masked normal status bits.
// - Raw normal status follows peripheral request lines; read only.
// - Writing 1 to normal enable sets mask bit; 0 ignored; readable.
// - Each 1 written to normal mask-clear clears that enable bit.
// - Masked normal status is raw AND enable except the software part of bit 1; plain mode has no vector.
// - OR of fast masked bits 31..1 is fast request and bit 0 of both raws.
// - Setting fast enable bit clears the same normal enable bit.
// - Setting normal enable bit clears the same fast enable bit.
// - Raw fast status follows peripheral fast request lines.
// - Writing 1 to fast enable sets mask bit; 0 never disables.
// - Each 1 written to fast mask-clear clears that fast enable bit.
// - Masked fast status is raw fast AND fast enable, except the software part of bit 1.
// - Software register bit 2 drives fast bit 1, raw and masked, unmaskable.
// - Software register bit 1 drives normal bit 1, raw and masked.
// - Nesting control bit 0 enables normal vectoring; bit 1 (fast) is stored only.
// - Vectored mode nests eight levels, normal type only; fast above normal.
// - Each prioritizable source gets a software priority 0 to 7.
// - Vector base holds 16 bits; upper bits read zero.
// - Vector register gives base at 22:7, source number at 6:2.
// - Priority 0 is highest, 7 lowest.
// - Reading vector sets in-service bit; that level and lower blocked.
// - With nesting off both levels work unprioritised; fast stays above.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defs.vh"
// Register map, all full 32-bit byte addresses
// 0xffff0000 normal masked status, read only
// 0xffff0004 normal raw status, read only
// 0xffff0008 normal enable, write ones to set
// 0xffff000c normal enable clear, write only
// 0xffff0010 software request bits, write only
// 0xffff0014 vector base, low 16 bits kept
// 0xffff001c active vector, read only
// 0xffff0020 priority fields, first group
// 0xffff0024 priority fields, second group
// 0xffff0028 priority fields, third group
// 0xffff0030 nesting control, two bits
// 0xffff003c in-service levels, eight bits
// 0xffff0100 fast masked status, read only
// 0xffff0104 fast raw status, read only
// 0xffff0108 fast enable, write ones to set
// 0xffff010c fast enable clear, write only
//
// Timing
// Bus has no wait states and never signals an error
// Writes land at the access edge
// Reads are combinational while the address is held
// Source lines reach status two edges after they change
// Software bits reach status one edge after the write
// Both requests to the core are combinational from flops
//
// Mask handling
// The two enable sets never share a bit
// Setting a bit on one level drops it on the other
// Otherwise clearing is done only through the clear registers
// Zero bits in any write leave the masks alone
//
// Fast level
// Fast bit 0 is the OR of fast masked bits 31 to 1
// That OR also shows as bit 0 of the normal raw status
// So a pending fast request can be seen by normal software
// Fast bit 0 is only an echo, never an input of the OR
//
// Vectored mode
// Enabled by nesting bit 0; only normal sources vector
// Fast nesting bit is stored but has no effect here
// Lower priority value is more urgent
// Ties go to the lowest source number
// Sources 0 and 16 to 19 have no priority field
// Such sources always sit at the most urgent level
// A vector read marks its level in service
// A marked level blocks itself and every lower level
// Clearing releases only the most urgent marked level
// Software must release levels in nesting order
//
// Hazards
// Vector read outside vectored mode gives the current best source but marks no level
// Sources above 19 count in status but never vector
// Reserved priority bits are dropped on write
// Raw status has no reset of its own beyond the sync flops
// Unmapped reads return zero, unmapped writes are lost
//
module dual_level_irq_ctrl (
   input wire ref_clk_i,
   input wire rst_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [31:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   input wire [31:0] normal_src_i,
   input wire [31:0] fast_src_i,
   output wire normal_irq_o,
   output wire fast_interrupt_o
);

   // Synchronised source lines
   reg [31:0] nsrc_meta_r;
   reg [31:0] nsrc_r;
   reg [31:0] fsrc_meta_r;
   reg [31:0] fsrc_r;
   // Software-visible state
   reg [31:0] normal_irq_enable_set_r;
   reg [31:0] fast_irq_enable_set_r;
   reg [1:0] software_interrupt_config_r;
   reg [15:0] vector_table_base_r;
   reg [31:0] priority_config_a_r;
   reg [31:0] priority_config_b_r;
   reg [31:0] priority_config_c_r;
   reg [1:0] nesting_control_r;
   reg [7:0] in_service_priority_r;

   wire [31:0] normal_irq_raw_status;
   wire [31:0] fast_irq_raw_status;
   wire [31:0] normal_irq_masked_status;
   wire [31:0] fast_irq_masked_status;
   wire fast_any;
   wire [31:1] fast_masked_hi;
   wire wr_en;
   wire rd_en;

   // Priority of a normal source; source 0 cannot be prioritised
   function [2:0] src_prio;
      input [4:0] idx;
      input [31:0] pa;
      input [31:0] pb;
      input [31:0] pc;
      begin
         case (idx)
            5'h01: src_prio = pa[6:4];
            5'h02: src_prio = pa[14:12];
            5'h03: src_prio = pa[18:16];
            5'h04: src_prio = pa[22:20];
            5'h05: src_prio = pa[26:24];
            5'h06: src_prio = pb[10:8];
            5'h07: src_prio = pb[14:12];
            5'h08: src_prio = pb[18:16];
            5'h09: src_prio = pb[22:20];
            5'h0a: src_prio = pb[26:24];
            5'h0b: src_prio = pb[30:28];
            5'h0c: src_prio = pc[2:0];
            5'h0d: src_prio = pc[6:4];
            5'h0e: src_prio = pc[10:8];
            5'h0f: src_prio = pc[14:12];
            default: src_prio = 3'h0;
         endcase
      end
   endfunction

   // Two-stage synchroniser for peripheral request lines
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         nsrc_meta_r <= `ZERO32;
         nsrc_r <= `ZERO32;
         fsrc_meta_r <= `ZERO32;
         fsrc_r <= `ZERO32;
      end else begin
         nsrc_meta_r <= normal_src_i;
         nsrc_r <= nsrc_meta_r;
         fsrc_meta_r <= fast_src_i;
         fsrc_r <= fsrc_meta_r;
      end
   end

   assign fast_masked_hi = {fsrc_r[31:2] & fast_irq_enable_set_r[31:2],
                            software_interrupt_config_r[1] | (fsrc_r[1] & fast_irq_enable_set_r[1])};
   // fast request from bits 31..1; bit 0 is raw echo AND its enable
   assign fast_any = |fast_masked_hi;
   assign fast_irq_masked_status = {fast_masked_hi, fast_any & fast_irq_enable_set_r[0]};
   assign fast_interrupt_o = fast_any;
   // raw fast status with software bit
   assign fast_irq_raw_status = {fsrc_r[31:2], software_interrupt_config_r[1] | fsrc_r[1], fast_any};
   assign normal_irq_raw_status = {nsrc_r[31:2], software_interrupt_config_r[0] | nsrc_r[1], fast_any};
   assign normal_irq_masked_status = {normal_irq_raw_status[31:2] & normal_irq_enable_set_r[31:2],
                                      software_interrupt_config_r[0] | (nsrc_r[1] & normal_irq_enable_set_r[1]),
                                      fast_any & normal_irq_enable_set_r[0]};

   // Highest priority active normal source; strict compare keeps lowest index
   reg [4:0] best_idx;
   reg [2:0] best_pri;
   reg best_vld;
   reg [3:0] blk_lvl;
   integer i;
   always @* begin
      best_idx = 5'h00;
      best_pri = 3'h7;
      best_vld = 1'b0;
      blk_lvl = 4'h8;
      // lowest set in-service bit bounds the allowed levels
      for (i = 7; i >= 0; i = i - 1) begin
         if (in_service_priority_r[i]) begin
            blk_lvl = i[3:0];
         end
      end
      for (i = 0; i < `NUM_SRC; i = i + 1) begin
         if (normal_irq_masked_status[i] &&
             ({1'b0, src_prio(i[4:0], priority_config_a_r, priority_config_b_r, priority_config_c_r)} < blk_lvl) &&
             (!best_vld || src_prio(i[4:0], priority_config_a_r, priority_config_b_r, priority_config_c_r) < best_pri)) begin
            best_vld = 1'b1;
            best_idx = i[4:0];
            best_pri = src_prio(i[4:0], priority_config_a_r, priority_config_b_r, priority_config_c_r);
         end
      end
   end

   // normal request; nesting blocks levels in service
   assign normal_irq_o = nesting_control_r[`NEST_NORM_BIT] ? best_vld : |normal_irq_masked_status;

   // APB: zero wait states, no error
   assign pready_o = 1'b1;
   assign pslverr_o = 1'b0;
   assign wr_en = psel_i & penable_i & pwrite_i;
   assign rd_en = psel_i & penable_i & ~pwrite_i;

   // Lowest set in-service bit, the only one clearable
   reg [7:0] isr_low;
   integer k;
   always @* begin
      isr_low = 8'h00;
      for (k = 7; k >= 0; k = k - 1) begin
         if (in_service_priority_r[k]) begin
            isr_low = 8'h01 << k;
         end
      end
   end

   // Register writes and side effects
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         normal_irq_enable_set_r <= `ZERO32;
         fast_irq_enable_set_r <= `ZERO32;
         software_interrupt_config_r <= 2'h0;
         vector_table_base_r <= 16'h0000;
         priority_config_a_r <= `ZERO32;
         priority_config_b_r <= `ZERO32;
         priority_config_c_r <= `ZERO32;
         nesting_control_r <= 2'h0;
         in_service_priority_r <= 8'h00;
      end else begin
         if (wr_en) begin
            if (paddr_i == `NEN_ADDR) begin
               normal_irq_enable_set_r <= normal_irq_enable_set_r | pwdata_i;
               fast_irq_enable_set_r <= fast_irq_enable_set_r & ~pwdata_i;
            end else if (paddr_i == `NCLR_ADDR) begin
               normal_irq_enable_set_r <= normal_irq_enable_set_r & ~pwdata_i;
            end else if (paddr_i == `FEN_ADDR) begin
               fast_irq_enable_set_r <= fast_irq_enable_set_r | pwdata_i;
               normal_irq_enable_set_r <= normal_irq_enable_set_r & ~pwdata_i;
            end else if (paddr_i == `FCLR_ADDR) begin
               fast_irq_enable_set_r <= fast_irq_enable_set_r & ~pwdata_i;
            end else if (paddr_i == `SWI_ADDR) begin
               software_interrupt_config_r <= {pwdata_i[`SWI_FAST_BIT], pwdata_i[`SWI_NORM_BIT]};
            end else if (paddr_i == `VBASE_ADDR) begin
               vector_table_base_r <= pwdata_i[15:0];
            end else if (paddr_i == `PRIA_ADDR) begin
               priority_config_a_r <= pwdata_i & `PRIA_MASK;
            end else if (paddr_i == `PRIB_ADDR) begin
               priority_config_b_r <= pwdata_i & `PRIB_MASK;
            end else if (paddr_i == `PRIC_ADDR) begin
               priority_config_c_r <= pwdata_i & `PRIC_MASK;
            end else if (paddr_i == `NEST_ADDR) begin
               nesting_control_r <= pwdata_i[1:0];
            end else if (paddr_i == `INSV_ADDR) begin
               // Only the lowest set in-service bit clears per write
               in_service_priority_r <= in_service_priority_r & ~(isr_low & pwdata_i[7:0]);
            end
         end else if (rd_en && paddr_i == `VEC_ADDR && nesting_control_r[`NEST_NORM_BIT] && best_vld) begin
            // vector read marks level in service
            // one bit per level, eight levels
            in_service_priority_r <= in_service_priority_r | (8'h01 << best_pri);
         end
      end
   end

   // Read data mux
   always @* begin
      // Unmapped and write-only places read zero
      prdata_o = `ZERO32;
      // Status, enables, base, vector, priority, nesting, fast group
      if (paddr_i == `NSTA_ADDR) begin
         prdata_o = normal_irq_masked_status;
      end else if (paddr_i == `NRAW_ADDR) begin
         prdata_o = normal_irq_raw_status;
      end else if (paddr_i == `NEN_ADDR) begin
         prdata_o = normal_irq_enable_set_r;
      end else if (paddr_i == `VBASE_ADDR) begin
         prdata_o = {16'h0000, vector_table_base_r};
      end else if (paddr_i == `VEC_ADDR) begin
         // base and source number; valid only with nesting on
         prdata_o = {9'h000, vector_table_base_r, best_idx, 2'h0};
      end else if (paddr_i == `PRIA_ADDR) begin
         prdata_o = priority_config_a_r;
      end else if (paddr_i == `PRIB_ADDR) begin
         prdata_o = priority_config_b_r;
      end else if (paddr_i == `PRIC_ADDR) begin
         prdata_o = priority_config_c_r;
      end else if (paddr_i == `NEST_ADDR) begin
         prdata_o = {30'h00000000, nesting_control_r};
      end else if (paddr_i == `INSV_ADDR) begin
         prdata_o = {24'h000000, in_service_priority_r};
      end else if (paddr_i == `FSTA_ADDR) begin
         prdata_o = fast_irq_masked_status;
      end else if (paddr_i == `FRAW_ADDR) begin
         prdata_o = fast_irq_raw_status;
      end else if (paddr_i == `FEN_ADDR) begin
         prdata_o = fast_irq_enable_set_r;
      end
   end

endmodule
`default_nettype wire

// >>> rtl/irq_ctrl_defs.vh
// Register map, field positions and reset values of the dual-level interrupt controller
`ifndef IRQ_CTRL_DEFS_VH
`define IRQ_CTRL_DEFS_VH
`define NSTA_ADDR 32'hffff0000
`define NRAW_ADDR 32'hffff0004
`define NEN_ADDR 32'hffff0008
`define NCLR_ADDR 32'hffff000c
`define SWI_ADDR 32'hffff0010
`define VBASE_ADDR 32'hffff0014
`define VEC_ADDR 32'hffff001c
`define PRIA_ADDR 32'hffff0020
`define PRIB_ADDR 32'hffff0024
`define PRIC_ADDR 32'hffff0028
`define NEST_ADDR 32'hffff0030
`define INSV_ADDR 32'hffff003c
`define FSTA_ADDR 32'hffff0100
`define FRAW_ADDR 32'hffff0104
`define FEN_ADDR 32'hffff0108
`define FCLR_ADDR 32'hffff010c
`define SWI_FAST_BIT 2
`define SWI_NORM_BIT 1
`define SRC_SWI 1
`define NUM_SRC 20
`define NEST_NORM_BIT 0
`define NEST_FAST_BIT 1
`define VEC_BASE_LSB 7
`define VEC_SRC_LSB 2
`define ZERO32 32'h00000000
`define PRIA_MASK 32'h07777070
`define PRIB_MASK 32'h77777700
`define PRIC_MASK 32'h00007777
`endif

// >>> sim/dual_level_irq_ctrl_monitor.sv
// Port checker for the dual-level interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defs.vh"
module dual_level_irq_ctrl_monitor (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic [31:0] normal_src_i,
   input wire logic [31:0] fast_src_i,
   input wire logic normal_irq_o,
   input wire logic fast_interrupt_o
);
   logic nest_r;
   logic [1:0] up_r;
   wire logic rd = psel_i && penable_i && !pwrite_i;
   wire logic wr = psel_i && penable_i && pwrite_i;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // Track vectored mode and cycles since reset
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         nest_r <= 1'b0;
         up_r <= 2'h0;
      end else begin
         if (wr && paddr_i == `NEST_ADDR) nest_r <= pwdata_i[`NEST_NORM_BIT];
         if (up_r != 2'h3) up_r <= up_r + 2'h1;
      end
   end
   a_base_upper: assert property (rd && paddr_i == `VBASE_ADDR |-> prdata_o[31:16] == 16'h0)
      else $error("base upper bits not zero");
   a_vec_layout: assert property (rd && paddr_i == `VEC_ADDR |->
      prdata_o[31:23] == 9'h0 && prdata_o[1:0] == 2'h0 && prdata_o[6:2] <= 5'h13)
      else $error("vector layout wrong");
   a_fast_or: assert property (rd && paddr_i == `FSTA_ADDR |-> fast_interrupt_o == |prdata_o[31:1])
      else $error("fast request not OR of status");
   a_fraw_bit0: assert property (rd && paddr_i == `FRAW_ADDR |-> prdata_o[0] == fast_interrupt_o)
      else $error("fast raw bit 0 wrong");
   a_norm_or: assert property (rd && paddr_i == `NSTA_ADDR && !nest_r |-> normal_irq_o == |prdata_o)
      else $error("normal request not OR of status");
   a_raw_follow: assert property (rd && paddr_i == `FRAW_ADDR && up_r == 2'h3 && $stable(fast_src_i)
      && $past(fast_src_i, 2) == fast_src_i |-> prdata_o[31:2] == fast_src_i[31:2])
      else $error("fast raw does not follow sources");
   a_swi_fast: assert property (wr && paddr_i == `SWI_ADDR && pwdata_i[2] |=> fast_interrupt_o)
      else $error("software fast request missing");
   a_swi_norm: assert property (wr && paddr_i == `SWI_ADDR && pwdata_i[1] && !nest_r |=> normal_irq_o)
      else $error("software normal request missing");
   cover property (wr && paddr_i == `SWI_ADDR && pwdata_i[2]);
   cover property (rd && paddr_i == `VEC_ADDR && nest_r);
   cover property (rd && paddr_i == `FSTA_ADDR && fast_interrupt_o);
endmodule
bind dual_level_irq_ctrl dual_level_irq_ctrl_monitor u_mon (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .normal_src_i(normal_src_i), .fast_src_i(fast_src_i),
   .normal_irq_o(normal_irq_o), .fast_interrupt_o(fast_interrupt_o));
`default_nettype wire

// >>> sim/dual_level_irq_ctrl_tb.sv
// Self-checking bench for the dual-level interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defs.vh"
module dual_level_irq_ctrl_tb;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b0;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, nreq = 32'h0, freq = 32'h0;
   logic [31:0] prdata, nsrc, fsrc, r, ns, fs, ne, fe, c, b, fst, nraw, nst;
   logic pready, pslverr, nirq, firq;
   int n_errors = 0, check_count = 0, cyc = 0;
   logic [31:0] zl [9] = '{`NSTA_ADDR, `NRAW_ADDR, `NEN_ADDR, `VBASE_ADDR, `VEC_ADDR, `FSTA_ADDR,
      `FRAW_ADDR, `FEN_ADDR, 32'hffff0200};
   always #12.5 ref_clk_i = ~ref_clk_i;
   dual_level_irq_ctrl u_dual_level_irq_ctrl (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .normal_src_i(nsrc), .fast_src_i(fsrc), .normal_irq_o(nirq), .fast_interrupt_o(firq));
   irq_src_model u_irq_src_model (.clk_i(ref_clk_i), .rst_i(rst_i), .n_req_i(nreq), .f_req_i(freq),
      .n_src_o(nsrc), .f_src_o(fsrc));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // One APB transfer, held until ready is sampled high
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk_i);
      pen <= 1'b1;
      do @(posedge ref_clk_i); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(r, e);
   endtask
   task automatic results;
      $display("checks=%0d errors=%0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Fast masked status: enabled sources plus unmaskable software bit, bit 0 from the OR
   function automatic logic [31:0] fsta_of(input logic [31:0] f, input logic [31:0] en, input logic s);
      logic [31:0] m;
      m = (f & en & 32'hfffffffc) | {30'h0, s, 1'b0};
      m[0] = (|m[31:1]) & en[0];
      return m;
   endfunction
   function automatic logic [4:0] low_src(input logic [31:0] v);
      low_src = 5'h0;
      for (int i = 19; i >= 0; i--) if (v[i]) low_src = i[4:0];
   endfunction
   // Cut a hang short
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         results;
      end
   end
   initial begin
      rst_i <= 1'b1;
      void'($urandom(32'h4272));
      repeat (6) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      // Writes to read-only and unmapped places change nothing
      apb(1'b1, `NSTA_ADDR, 32'hffffffff);
      apb(1'b1, `FRAW_ADDR, 32'hffffffff);
      apb(1'b1, 32'hffff0200, 32'hffffffff);
      foreach (zl[i]) rd(zl[i], 32'h0);
      // Random sources, masks and software bits
      for (int k = 0; k < 12; k++) begin
         ns = $urandom & 32'hfffffffc;
         fs = $urandom & 32'hfffffffc;
         ne = $urandom;
         fe = $urandom;
         c = $urandom;
         apb(1'b1, `NCLR_ADDR, 32'hffffffff);
         apb(1'b1, `FCLR_ADDR, 32'hffffffff);
         apb(1'b1, `NEN_ADDR, ne);
         apb(1'b1, `NEN_ADDR, 32'h0);
         apb(1'b1, `FEN_ADDR, fe);
         apb(1'b1, `SWI_ADDR, c);
         nreq <= ns;
         freq <= fs;
         repeat (8) @(posedge ref_clk_i);
         ne = ne & ~fe;
         fst = fsta_of(fs, fe, c[2]);
         nraw = {ns[31:2], c[1], |fst[31:1]};
         nst = (nraw & ne) | {30'h0, c[1], 1'b0};
         rd(`FEN_ADDR, fe);
         rd(`NEN_ADDR, ne);
         rd(`FRAW_ADDR, {fs[31:2], c[2], |fst[31:1]});
         rd(`FSTA_ADDR, fst);
         rd(`NRAW_ADDR, nraw);
         rd(`NSTA_ADDR, nst);
         chk({30'h0, nirq, firq}, {30'h0, |nst, |fst[31:1]});
         c = $urandom;
         apb(1'b1, `NEN_ADDR, c);
         rd(`FEN_ADDR, fe & ~c);
         apb(1'b1, `NCLR_ADDR, c);
         rd(`NEN_ADDR, ne & ~c);
         apb(1'b1, `FCLR_ADDR, ~c);
         rd(`FEN_ADDR, 32'h0);
      end
      // Vectored mode: equal priorities pick the lowest source, reading blocks the level
      nreq <= ($urandom & 32'h000ffff0) | 32'h00080000;
      freq <= 32'h0;
      apb(1'b1, `SWI_ADDR, 32'h0);
      apb(1'b1, `FCLR_ADDR, 32'hffffffff);
      apb(1'b1, `NEN_ADDR, 32'hffffffff);
      b = $urandom;
      apb(1'b1, `VBASE_ADDR, b);
      apb(1'b1, `NEST_ADDR, 32'h1);
      repeat (8) @(posedge ref_clk_i);
      rd(`VBASE_ADDR, b & 32'h0000ffff);
      chk({31'h0, nirq}, 32'h1);
      // vector read only with a normal request and nesting on
      rd(`VEC_ADDR, {9'h0, b[15:0], low_src(nreq), 2'h0});
      @(posedge ref_clk_i);
      chk({31'h0, nirq}, 32'h0);
      apb(1'b1, `INSV_ADDR, 32'h000000ff);
      @(posedge ref_clk_i);
      chk({31'h0, nirq}, 32'h1);
      // Push configurable sources to level 7; fixed ones stay most urgent
      apb(1'b1, `PRIA_ADDR, 32'hffffffff);
      apb(1'b1, `PRIB_ADDR, 32'hffffffff);
      apb(1'b1, `PRIC_ADDR, 32'hffffffff);
      rd(`PRIA_ADDR, `PRIA_MASK);
      rd(`PRIB_ADDR, `PRIB_MASK);
      rd(`PRIC_ADDR, `PRIC_MASK);
      rd(`VEC_ADDR, {9'h0, b[15:0], low_src(nreq & 32'h000f0000), 2'h0});
      rd(`INSV_ADDR, 32'h1);
      results;
   end
endmodule
`default_nettype wire

// >>> sim/irq_src_model.sv
// Peripheral request model that holds each request level a minimum time
`timescale 1ns/1ps
`default_nettype none
module irq_src_model #(parameter int HOLD = 4) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [31:0] n_req_i,
   input wire logic [31:0] f_req_i,
   output logic [31:0] n_src_o,
   output logic [31:0] f_src_o
);
   int cnt;
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt <= 0;
         n_src_o <= 32'h0;
         f_src_o <= 32'h0;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end else if ({n_req_i, f_req_i} != {n_src_o, f_src_o}) begin
         n_src_o <= n_req_i;
         f_src_o <= f_req_i;
         cnt <= HOLD;
      end
   end
endmodule
`default_nettype wire
